/* File: hdl/serial_rx_pkg.sv */
`default_nettype none
package serial_rx_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE    = 8'h00;
  localparam logic [7:0] OFS_BAUD    = 8'h04;
  localparam logic [7:0] OFS_RXBUF   = 8'h08;
  localparam logic [7:0] OFS_ERRSTAT = 8'h0c;
  localparam logic [7:0] OFS_TXDATA  = 8'h10;
  localparam logic [7:0] OFS_STATE   = 8'h14;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int MODE_TXE_BIT   = 7;
  localparam int MODE_RXE_BIT   = 6;
  localparam int MODE_PAR_LSB   = 4;
  localparam int MODE_CHAR8_BIT = 3;
  localparam int MODE_STOP2_BIT = 2;
  localparam int BAUD_PRE_LSB   = 4;
  localparam int ERR_PAR_BIT    = 2;
  localparam int ERR_FRM_BIT    = 1;
  localparam int ERR_OVR_BIT    = 0;
  localparam int ST_TXFLAG_BIT  = 0;
  localparam logic [7:0] MODE_RST     = 8'h00;
  localparam logic [7:0] BAUD_RST     = 8'h00;
  localparam logic [7:0] BAUD_WR_MASK = 8'h7f;

  // half bit lasts k+16 counter source ticks; this is that count minus one
  localparam logic [4:0] HALF_BASE = 5'h0f;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD  = 2'h2,
    PAR_EVEN = 2'h3
  } par_mode_t;

  typedef enum logic [2:0] {
    RX_IDLE   = 3'h0,
    RX_START  = 3'h1,
    RX_DATA   = 3'h3,
    RX_PARITY = 3'h2,
    RX_STOP   = 3'h6,
    RX_DONE   = 3'h4
  } rx_state_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
  } ahb_req_t;

  typedef struct packed {
    logic rx_error;
    logic rx_done;
    logic tx_done;
  } irq_t;

endpackage
`default_nettype wire

/* File: hdl/async_serial_receiver.sv */
// Overview of operation
// - receiver samples the line only while the receive enable bit is one
// - sampling is paced by the serial clock chosen by configuration
// - falling input starts the 5-bit counter; half a bit later a start strobe
// - low at the start strobe accepts the start bit and restarts the counter
// - character bits, parity and one stop bit complete the frame
// - completed frame goes into the receive buffer with a completion interrupt
// - erroneous frames are still buffered and still raise completion
// - clearing receive enable aborts at once; buffer, status, interrupts untouched
// - parity, framing and overrun errors raise the error interrupt
// - error interrupt comes before that frame's completion interrupt
// - error status clears on buffer read or next frame, which may set it again
// - status codes: parity 04h, framing 02h, overrun 01h
// - framing error when the stop bit samples low
// - overrun when a frame completes while the previous one is unread
// - software reads the buffer after errors, else overruns repeat
// - transmit completion raises its interrupt and sets a request flag
// - serial transfers keep running during halt standby
// - stop mode halts transfers; mode, shift and buffer registers hold
// - transmit output holds its level while the clock is stopped
// - a reception stopped by stop mode keeps its bits and may resume
// - frame: start, 7 or 8 data bits, optional parity, 1 or 2 stops
// - even parity errs on odd ones, odd on even; zero and none never err
// - only the first stop bit is checked on receive
// - bit clock divides by two to the n plus one, then by two times (k plus 16)
`timescale 1ns/1ps
`default_nettype none
module async_serial_receiver (
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire serial_rx_pkg::ahb_req_t  bus_in,
  input  wire logic [31:0]              hwdata_in,
  input  wire logic                     hready_in,
  output logic [31:0]                   hrdata_out,
  output logic                          hreadyout_out,
  output logic                          hresp_out,
  input  wire logic                     serial_in_line_in,
  input  wire logic                     stop_mode_in,
  output logic                          serial_out_line_out,
  output serial_rx_pkg::irq_t           irq_out
);
  import serial_rx_pkg::*;

  logic [7:0]  serial_mode_reg;
  logic [7:0]  baud_ctrl_reg;
  logic [7:0]  rx_buffer;
  logic [7:0]  rx_shift_reg;
  logic [2:0]  rx_error_status;
  logic        unread_reg;
  logic        tx_done_req_flag;
  rx_state_t   rx_state_reg;
  logic [4:0]  rx_div_reg;
  logic        phase_reg;
  logic [2:0]  bit_cnt_reg;
  logic        par_acc_reg;
  logic        sync1_reg;
  logic        sync2_reg;
  logic        sync3_reg;
  logic [7:0]  pre_cnt_reg;
  logic        err_irq_reg;
  logic        done_irq_reg;
  logic        tx_irq_reg;
  logic        tx_busy_reg;
  logic [10:0] tx_frame_reg;
  logic [3:0]  tx_left_reg;
  logic [5:0]  tx_div_reg;
  logic        tx_out_reg;
  logic [31:0] hrdata_reg;
  logic        dp_valid_reg;
  logic        dp_write_reg;
  logic [7:0]  dp_addr_reg;

  // ----------------------------------------------------------------
  // decoded configuration
  // ----------------------------------------------------------------
  logic       rx_en;
  logic       tx_en;
  logic       char8;
  logic       stop2;
  par_mode_t  pmode;
  logic       par_on;
  logic [4:0] half_limit;
  logic [5:0] bit_limit;
  logic [7:0] pre_mask;
  logic       fsck_tick;

  assign rx_en  = serial_mode_reg[MODE_RXE_BIT];
  assign tx_en  = serial_mode_reg[MODE_TXE_BIT];
  assign char8  = serial_mode_reg[MODE_CHAR8_BIT];
  assign stop2  = serial_mode_reg[MODE_STOP2_BIT];
  assign pmode  = par_mode_t'(serial_mode_reg[MODE_PAR_LSB +: 2]);
  assign par_on = (pmode != PAR_NONE);
  assign half_limit = 5'(HALF_BASE + {1'b0, baud_ctrl_reg[3:0]});
  assign bit_limit  = {half_limit, 1'b1};
  assign pre_mask   = 8'((9'h002 << baud_ctrl_reg[BAUD_PRE_LSB +: 3]) - 9'h001);
  // counter source ticks freeze in stop mode, which holds the receive and transmit shift and timing registers
  assign fsck_tick  = !stop_mode_in && ((pre_cnt_reg & pre_mask) == pre_mask);

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      pre_cnt_reg <= 8'h00;
    else if (!stop_mode_in)
      pre_cnt_reg <= pre_cnt_reg + 8'h01;
  end

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= serial_in_line_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  logic fall;
  logic half_tick;
  logic in_bits;
  logic sample;
  logic stop_hit;
  logic bus_acc;
  logic buf_rd;
  logic wr;

  assign fall      = sync3_reg && !sync2_reg;
  assign half_tick = fsck_tick && (rx_div_reg == half_limit);
  assign in_bits   = (rx_state_reg == RX_DATA) || (rx_state_reg == RX_PARITY)
                     || (rx_state_reg == RX_STOP);
  assign sample    = in_bits && half_tick && phase_reg;
  assign stop_hit  = rx_en && (rx_state_reg == RX_STOP) && sample;
  assign bus_acc   = bus_in.hsel && bus_in.htrans[1] && hready_in;
  assign buf_rd    = bus_acc && !bus_in.hwrite && (bus_in.haddr[7:0] == OFS_RXBUF);
  assign wr        = dp_valid_reg && dp_write_reg;

  // ----------------------------------------------------------------
  // bit timing: half-bit counter and phase
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in || rx_state_reg == RX_IDLE || (rx_state_reg == RX_START && half_tick))
      rx_div_reg <= 5'h00;
    else if (fsck_tick)
      rx_div_reg <= half_tick ? 5'h00 : rx_div_reg + 5'h01;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in || rx_state_reg == RX_IDLE || rx_state_reg == RX_START)
      phase_reg <= 1'b0;
    else if (half_tick)
      phase_reg <= !phase_reg;
  end

  // ----------------------------------------------------------------
  // receive sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rx_state_reg <= RX_IDLE;
      rx_shift_reg <= 8'h00;
      bit_cnt_reg  <= 3'h0;
      par_acc_reg  <= 1'b0;
    end
    else if (!rx_en && rx_state_reg != RX_DONE)
      rx_state_reg <= RX_IDLE;
    else
    begin
      unique case (rx_state_reg)
        RX_IDLE:
          if (fall && !stop_mode_in)
            rx_state_reg <= RX_START;
        RX_START:
          if (half_tick)
          begin
            rx_state_reg <= sync2_reg ? RX_IDLE : RX_DATA;
            bit_cnt_reg  <= 3'h0;
            par_acc_reg  <= 1'b0;
          end
        RX_DATA:
          if (sample)
          begin
            rx_shift_reg <= {sync2_reg, rx_shift_reg[7:1]};
            par_acc_reg  <= par_acc_reg ^ sync2_reg;
            bit_cnt_reg  <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == (char8 ? 3'h7 : 3'h6))
              rx_state_reg <= par_on ? RX_PARITY : RX_STOP;
          end
        RX_PARITY:
          if (sample)
          begin
            par_acc_reg  <= par_acc_reg ^ sync2_reg;
            rx_state_reg <= RX_STOP;
          end
        RX_STOP:
          if (sample)
            rx_state_reg <= RX_DONE;
        RX_DONE:
          rx_state_reg <= RX_IDLE;
        default:
          rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // error status, receive buffer, interrupts
  // ----------------------------------------------------------------
  logic par_err;
  logic frm_err;
  logic ovr_err;

  assign par_err = ((pmode == PAR_EVEN) && par_acc_reg)
                   || ((pmode == PAR_ODD) && !par_acc_reg);
  assign frm_err = !sync2_reg;
  assign ovr_err = unread_reg && !buf_rd;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rx_error_status <= 3'h0;
    else if (stop_hit)
      rx_error_status <= {par_err, frm_err, ovr_err};
    else if (buf_rd)
      rx_error_status <= 3'h0;
  end

  // a new frame beats a buffer read landing in the same cycle
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rx_buffer  <= 8'h00;
      unread_reg <= 1'b0;
    end
    else if (rx_state_reg == RX_DONE)
    begin
      rx_buffer  <= char8 ? rx_shift_reg : {1'b0, rx_shift_reg[7:1]};
      unread_reg <= 1'b1;
    end
    else if (buf_rd)
      unread_reg <= 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      err_irq_reg  <= 1'b0;
      done_irq_reg <= 1'b0;
    end
    else
    begin
      err_irq_reg  <= stop_hit && (par_err || frm_err || ovr_err);
      done_irq_reg <= (rx_state_reg == RX_DONE);
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  logic        tx_start;
  logic [7:0]  tx_data;
  logic        tx_pb;
  logic [11:0] tx_load;
  logic [3:0]  tx_len;

  assign tx_start = wr && !stop_mode_in && (dp_addr_reg == OFS_TXDATA) && tx_en && !tx_busy_reg;
  assign tx_data  = char8 ? hwdata_in[7:0] : {1'b0, hwdata_in[6:0]};
  assign tx_pb    = (pmode == PAR_EVEN) ? ^tx_data
                  : (pmode == PAR_ODD) ? ~^tx_data
                  : (pmode == PAR_ZERO) ? 1'b0 : 1'b1;
  assign tx_load  = char8 ? {2'h3, tx_pb, tx_data, 1'b0}
                          : {3'h7, tx_pb, tx_data[6:0], 1'b0};
  assign tx_len   = 4'h1 + (char8 ? 4'h8 : 4'h7) + {3'h0, par_on} + (stop2 ? 4'h2 : 4'h1);

  // stalled ticks in stop mode leave the line at its last level
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      tx_busy_reg  <= 1'b0;
      tx_frame_reg <= 11'h7ff;
      tx_left_reg  <= 4'h0;
      tx_div_reg   <= 6'h00;
      tx_out_reg   <= 1'b1;
      tx_irq_reg   <= 1'b0;
    end
    else
    begin
      tx_irq_reg <= 1'b0;
      if (tx_start)
      begin
        tx_busy_reg  <= 1'b1;
        tx_frame_reg <= tx_load[11:1];
        tx_left_reg  <= tx_len - 4'h1;
        tx_div_reg   <= 6'h00;
        tx_out_reg   <= 1'b0;
      end
      else if (tx_busy_reg && fsck_tick)
      begin
        if (tx_div_reg != bit_limit)
          tx_div_reg <= tx_div_reg + 6'h01;
        else if (tx_left_reg == 4'h0)
        begin
          tx_busy_reg <= 1'b0;
          tx_irq_reg  <= 1'b1;
        end
        else
        begin
          tx_div_reg   <= 6'h00;
          tx_out_reg   <= tx_frame_reg[0];
          tx_frame_reg <= {1'b1, tx_frame_reg[10:1]};
          tx_left_reg  <= tx_left_reg - 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // bus slave and control registers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      OFS_MODE:    v = {24'h0, serial_mode_reg};
      OFS_BAUD:    v = {24'h0, baud_ctrl_reg};
      OFS_RXBUF:   v = {24'h0, rx_buffer};
      OFS_ERRSTAT: v = {29'h0, rx_error_status};
      OFS_STATE:   v = {29'h0, rx_state_reg != RX_IDLE, tx_busy_reg, tx_done_req_flag};
      default:     v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 8'h00;
      hrdata_reg   <= 32'h0000_0000;
    end
    else
    begin
      dp_valid_reg <= bus_acc;
      dp_write_reg <= bus_in.hwrite;
      dp_addr_reg  <= bus_in.haddr[7:0];
      if (bus_acc && !bus_in.hwrite)
        hrdata_reg <= rd_mux(bus_in.haddr[7:0]);
    end
  end

  // stop mode also blocks register writes so the mode register holds
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      serial_mode_reg <= MODE_RST;
      baud_ctrl_reg   <= BAUD_RST;
    end
    else if (wr && !stop_mode_in)
    begin
      if (dp_addr_reg == OFS_MODE)
        serial_mode_reg <= hwdata_in[7:0];
      if (dp_addr_reg == OFS_BAUD)
        baud_ctrl_reg <= hwdata_in[7:0] & BAUD_WR_MASK;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      tx_done_req_flag <= 1'b0;
    else if (tx_irq_reg)
      tx_done_req_flag <= 1'b1;
    else if (wr && !stop_mode_in && dp_addr_reg == OFS_STATE && hwdata_in[ST_TXFLAG_BIT])
      tx_done_req_flag <= 1'b0;
  end

  assign hrdata_out          = hrdata_reg;
  assign hreadyout_out       = 1'b1;
  assign hresp_out           = 1'b0;
  assign serial_out_line_out = tx_out_reg;
  assign irq_out             = '{rx_error: err_irq_reg, rx_done: done_irq_reg,
                                 tx_done: tx_irq_reg};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_disable_abort: assert property (@(posedge clk_in) disable iff (rst_in)
    (!rx_en && rx_state_reg != RX_IDLE && rx_state_reg != RX_DONE) |=>
      rx_state_reg == RX_IDLE && $stable(rx_buffer) && !done_irq_reg)
    else $error("reception not aborted on disable");

  chk_edge_start: assert property (@(posedge clk_in) disable iff (rst_in)
    (rx_en && rx_state_reg == RX_IDLE && fall && !stop_mode_in) |=> rx_state_reg == RX_START)
    else $error("falling edge did not start timing");

  chk_noise_reject: assert property (@(posedge clk_in) disable iff (rst_in)
    (rx_en && rx_state_reg == RX_START && half_tick && sync2_reg) |=> rx_state_reg == RX_IDLE)
    else $error("noise accepted as start bit");

  chk_error_order: assert property (@(posedge clk_in) disable iff (rst_in)
    err_irq_reg |=> done_irq_reg)
    else $error("error interrupt not followed by completion");

  chk_error_status: assert property (@(posedge clk_in) disable iff (rst_in)
    err_irq_reg |-> rx_error_status != 3'h0)
    else $error("error interrupt without status flag");

  chk_overrun_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    (stop_hit && unread_reg && !buf_rd) |=> rx_error_status[ERR_OVR_BIT] ##1 done_irq_reg)
    else $error("overrun not flagged");

  chk_read_clears: assert property (@(posedge clk_in) disable iff (rst_in)
    (buf_rd && !stop_hit) |=> rx_error_status == 3'h0)
    else $error("buffer read did not clear status");

  chk_stop_freeze: assert property (@(posedge clk_in) disable iff (rst_in)
    (stop_mode_in && rx_state_reg != RX_DONE && rx_state_reg != RX_START && rx_en)
      |=> $stable(rx_shift_reg) && $stable(serial_out_line_out) && $stable(serial_mode_reg))
    else $error("serial state moved in stop mode");

  chk_tx_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(tx_busy_reg) |-> irq_out.tx_done ##1 tx_done_req_flag)
    else $error("transmit completion not flagged");

endmodule  // async_serial_receiver
`default_nettype wire

/* File: bench/serial_tx_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// remote transmitter driving the receive line
// ------------------------------------------------------------
module serial_tx_model #(
  parameter int BIT_CLKS = 64
) (
  input  wire logic       clk_in,
  input  wire logic       start_in,
  input  wire logic       glitch_in,
  input  wire logic [7:0] data_in,
  input  wire logic [7:0] mode_in,
  input  wire logic       bad_par_in,
  input  wire logic [1:0] bad_stop_in,
  output logic            line_out,
  output logic            busy_out
);
  logic [11:0] frm = '1;
  logic        pbit;
  int          len = 0;
  int          idx = 0;
  int          cnt = 0;
  int          gcnt = 0;
  int          p;

  // idle line rests at its pull-up level, a glitch pulls it low briefly
  assign line_out = (busy_out ? frm[idx] : 1'b1) & (gcnt == 0);

  initial busy_out = 1'b0;

  always @(posedge clk_in)
  begin
    if (glitch_in)
      gcnt <= 10;  // far shorter than half a bit
    else if (gcnt != 0)
      gcnt <= gcnt - 1;
    if (start_in && !busy_out)
    begin
      pbit = ^(data_in & (mode_in[3] ? 8'hff : 8'h7f));
      if (mode_in[5:4] != 2'h3)
        pbit = (mode_in[5:4] == 2'h2) ? ~pbit : 1'b0;
      frm = '1;
      frm[0] = 1'b0;
      for (int i = 0; i < 8; i++)
        frm[1 + i] = data_in[i];
      // in 7-bit mode bit 7 is overwritten, so it never goes out
      p = mode_in[3] ? 9 : 8;
      frm[p] = pbit ^ bad_par_in;
      p = p + int'(mode_in[5:4] != 2'h0);
      frm[p] = ~bad_stop_in[0];
      frm[p + 1] = ~bad_stop_in[1];
      len = p + 1 + int'(mode_in[2]);
      idx <= 0;
      cnt <= 0;
      busy_out <= 1'b1;
    end
    else if (busy_out)
    begin
      if (cnt == BIT_CLKS - 1)
      begin
        cnt <= 0;
        idx <= idx + 1;
        busy_out <= (idx + 1 < len);
      end
      else
        cnt <= cnt + 1;
    end
  end
endmodule  // serial_tx_model
`default_nettype wire

/* File: bench/async_serial_receiver_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module async_serial_receiver_bench;
  import serial_rx_pkg::*;
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] data;
    logic       bp;
    logic [1:0] bs;
    logic [7:0] rbuf;
    logic [7:0] err;
  } row_t;
  // ------------------------------------------------------------
  // stimulus, partner and monitors
  // ------------------------------------------------------------
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  ahb_req_t    bus_in = '0;
  logic [31:0] hwdata_in = '0;
  logic [31:0] hrdata_out;
  logic        hreadyout_out;
  logic        hresp_out;
  logic        serial_in_line_in;
  logic        stop_mode_in = 1'b0;
  logic        serial_out_line_out;
  irq_t        irq_out;
  logic        tx_start = 1'b0;
  logic        glitch = 1'b0;
  logic [7:0]  tx_data = '0;
  logic [7:0]  tx_mode = '0;
  logic        bad_par = 1'b0;
  logic [1:0]  bad_stop = '0;
  logic        tx_busy;
  logic        err_seen = 1'b0;
  logic        done_after_err = 1'b0;
  int          done_cnt = 0;
  int          errirq_cnt = 0;
  int          txirq_cnt = 0;
  int          err_total = 0;
  int          n_compared = 0;
  logic [31:0] rd;
  row_t        rows [9] = '{
    '{8'h48, 8'ha5, 1'b0, 2'h0, 8'ha5, 8'h00}, '{8'h58, 8'h3c, 1'b1, 2'h0, 8'h3c, 8'h00},
    '{8'h68, 8'h0f, 1'b0, 2'h0, 8'h0f, 8'h00}, '{8'h68, 8'h0f, 1'b1, 2'h0, 8'h0f, 8'h04},
    '{8'h78, 8'h81, 1'b1, 2'h0, 8'h81, 8'h04}, '{8'h78, 8'h7e, 1'b0, 2'h0, 8'h7e, 8'h00},
    '{8'h40, 8'hd5, 1'b0, 2'h0, 8'h55, 8'h00}, '{8'h4c, 8'hc3, 1'b0, 2'h2, 8'hc3, 8'h00},
    '{8'h48, 8'h96, 1'b0, 2'h1, 8'h96, 8'h02}};

  always #25 clk_in = ~clk_in;

  async_serial_receiver async_serial_receiver_inst (
    .clk_in(clk_in), .rst_in(rst_in), .bus_in(bus_in), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .serial_in_line_in(serial_in_line_in),
    .stop_mode_in(stop_mode_in), .serial_out_line_out(serial_out_line_out),
    .irq_out(irq_out));

  serial_tx_model #(.BIT_CLKS(64)) serial_tx_model_inst (
    .clk_in(clk_in), .start_in(tx_start), .glitch_in(glitch), .data_in(tx_data),
    .mode_in(tx_mode), .bad_par_in(bad_par), .bad_stop_in(bad_stop),
    .line_out(serial_in_line_in), .busy_out(tx_busy));

  // pulses last one cycle, so they are counted at every edge
  always @(posedge clk_in)
  begin
    err_seen <= (irq_out.rx_error === 1'b1);
    if (irq_out.rx_error === 1'b1)
      errirq_cnt <= errirq_cnt + 1;
    if (irq_out.rx_done === 1'b1)
    begin
      done_cnt <= done_cnt + 1;
      done_after_err <= err_seen;
    end
    if (irq_out.tx_done === 1'b1)
      txirq_cnt <= txirq_cnt + 1;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    bus_in <= '{1'b1, {24'h0, a}, 2'h2, wr, 3'h2};
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1)
      @(posedge clk_in);
    bus_in <= '0;
    hwdata_in <= wd;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1)
      @(posedge clk_in);
    rd = hrdata_out;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    check(rd, exp, what);
  endtask

  task automatic send(input logic [7:0] m, input logic [7:0] d, input logic bp,
                      input logic [1:0] bs);
    tx_mode <= m;
    tx_data <= d;
    bad_par <= bp;
    bad_stop <= bs;
    tx_start <= 1'b1;
    @(posedge clk_in);
    tx_start <= 1'b0;
    @(posedge clk_in);
    while (tx_busy)
      @(posedge clk_in);
  endtask

  task automatic wait_done(input int n);
    for (int t = 0; t < 1000 && done_cnt < n; t++)
      @(posedge clk_in);
    check(done_cnt, n, "completions");
  endtask

  task automatic finish_test();
    $display("compared %0d, wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial
  begin
    int n;
    int e;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    for (int r = 0; r < 9; r++)
    begin
      wr(OFS_MODE, rows[r].mode);
      n = done_cnt + 1;
      send(rows[r].mode, rows[r].data, rows[r].bp, rows[r].bs);
      wait_done(n);
      check(done_after_err, rows[r].err != 0, "error pulse first");
      rdchk(OFS_ERRSTAT, rows[r].err, "status");
      rdchk(OFS_RXBUF, rows[r].rbuf, "buffer");
      if (rows[r].bs[1])
      begin
        // a low second stop bit looks like a fresh start edge
        wait_done(n + 1);
        rdchk(OFS_RXBUF, 32'hff, "second stop as start");
      end
    end
    // two frames back to back, the first left unread
    n = done_cnt;
    send(8'h48, 8'h11, 1'b0, 2'h0);
    send(8'h48, 8'h22, 1'b0, 2'h0);
    wait_done(n + 2);
    check(done_after_err, 1'b1, "overrun pulse");
    rdchk(OFS_ERRSTAT, 32'h01, "overrun");
    send(8'h48, 8'h33, 1'b0, 2'h0);
    wait_done(n + 3);
    rdchk(OFS_ERRSTAT, 32'h01, "overrun again");
    rdchk(OFS_RXBUF, 32'h33, "latest frame");
    rdchk(OFS_ERRSTAT, 32'h00, "cleared by read");
    // a short low pulse must not start a frame
    glitch <= 1'b1;
    @(posedge clk_in);
    glitch <= 1'b0;
    repeat (768) @(posedge clk_in);
    check(done_cnt, n + 3, "noise dropped");
    send(8'h48, 8'h5a, 1'b0, 2'h0);
    wait_done(n + 4);
    rdchk(OFS_RXBUF, 32'h5a, "after noise");
    // receive disabled mid-frame
    e = errirq_cnt;
    fork
      send(8'h48, 8'hf0, 1'b1, 2'h1);
      begin
        repeat (256) @(posedge clk_in);
        wr(OFS_MODE, 8'h08);
      end
    join
    repeat (8) @(posedge clk_in);
    check(done_cnt, n + 4, "aborted frame");
    check(errirq_cnt, e, "no error pulse");
    rdchk(OFS_ERRSTAT, 32'h00, "status kept");
    rdchk(OFS_RXBUF, 32'h5a, "buffer kept");
    // stop standby freezes reception and register writes
    wr(OFS_MODE, 8'h48);
    stop_mode_in <= 1'b1;
    wr(OFS_MODE, 8'h00);
    rdchk(OFS_MODE, 32'h48, "mode held");
    send(8'h48, 8'h77, 1'b0, 2'h0);
    repeat (8) @(posedge clk_in);
    check(done_cnt, n + 4, "frozen");
    rdchk(OFS_RXBUF, 32'h5a, "buffer held");
    stop_mode_in <= 1'b0;
    @(posedge clk_in);
    send(8'h48, 8'h99, 1'b0, 2'h0);
    wait_done(n + 5);
    rdchk(OFS_RXBUF, 32'h99, "after standby");
    // standby in mid-frame: bits after release are taken one bit later
    fork
      send(8'h48, 8'h3c, 1'b0, 2'h0);
      begin
        repeat (200) @(posedge clk_in);
        stop_mode_in <= 1'b1;
        repeat (62) @(posedge clk_in);
        bus(1'b0, OFS_STATE, 32'h0);
        check({31'h0, rd[2]}, 32'h1, "reception held");
        stop_mode_in <= 1'b0;
      end
    join
    wait_done(n + 6);
    rdchk(OFS_RXBUF, 32'h9c, "resumed frame");
    // transmit completion; mode is left alone until it ends
    wr(OFS_MODE, 8'hc8);
    n = txirq_cnt;
    wr(OFS_TXDATA, 8'h5a);
    repeat (150) @(posedge clk_in);
    stop_mode_in <= 1'b1;
    repeat (100) @(posedge clk_in);
    check({31'h0, serial_out_line_out}, 32'h1, "tx line held");
    stop_mode_in <= 1'b0;
    for (int t = 0; t < 2000 && txirq_cnt == n; t++)
      @(posedge clk_in);
    check(txirq_cnt, n + 1, "tx pulse");
    bus(1'b0, OFS_STATE, 32'h0);
    check({31'h0, rd[ST_TXFLAG_BIT]}, 32'h1, "tx flag");
    check({31'h0, serial_out_line_out}, 32'h1, "tx idle");
    // second reset in mid-run
    rst_in <= 1'b1;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rdchk(OFS_MODE, {24'h0, MODE_RST}, "mode reset");
    rdchk(OFS_RXBUF, 32'h0, "buffer reset");
    wr(OFS_BAUD, 8'hff);
    rdchk(OFS_BAUD, {24'h0, BAUD_WR_MASK}, "baud bit 7");
    wr(8'h1c, 8'hff);
    rdchk(8'h1c, 32'h0, "unmapped");
    check({31'h0, hresp_out}, 32'h0, "okay");
    finish_test();
  end

  initial
  begin
    repeat (40000) @(posedge clk_in);
    err_total++;
    $display("wrong value at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule  // async_serial_receiver_bench
`default_nettype wire
